// ==== rtl/dmsd_map.vh ====
// constants for the data memory space decoder
`ifndef DMSD_MAP_VH
`define DMSD_MAP_VH
// ************************************************************
// address boundaries
// ************************************************************
`define DMSD_LOWER_RAM_TOP 8'h7F
`define DMSD_IRAM_BYTES 256
`define DMSD_AUX_RAM_BYTES 256
// ************************************************************
// access kinds on the core request
// ************************************************************
`define DMSD_KIND_DIRECT 2'h0
`define DMSD_KIND_INDIRECT 2'h1
`define DMSD_KIND_XMOVE_IDX 2'h2
`define DMSD_KIND_XMOVE_PTR 2'h3
// ************************************************************
// external bus cycle phases
// ************************************************************
`define DMSD_PH_IDLE 2'h0
`define DMSD_PH_ADDR 2'h1
`define DMSD_PH_STROBE 2'h2
`define DMSD_PH_DONE 2'h3
// ************************************************************
// reset values and strobe length
// ************************************************************
`define DMSD_PORT_RESET 8'hFF
`define DMSD_STROBE_LEN 2
`endif

// ==== rtl/dmsd_ram.v ====
// single-port byte ram used for the on-chip storage arrays
`timescale 1ns/1ps
module dmsd_ram #(
    parameter AW = 8,
    parameter DEPTH = 256
) (
    input wire clock,
    input wire wr_en,
    input wire [AW-1:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clock) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ==== rtl/dmsd_decoder.v ====
// data memory space decoder: steers core accesses to ram, registers or the external bus
`timescale 1ns/1ps
`include "dmsd_map.vh"
// Operation
// [R1] lower 128 bytes: direct and indirect
// [R2] upper 128 bytes: indirect only
// [R3] direct above 7F goes to registers
// [R4] upper ram separate from register space
// [R5] aux ram sized per variant, from zero
// [R6] bypass clear: in-range moves hit aux ram
// [R7] aux ram access leaves bus pins idle
// [R8] high address port stays output
// [R9] bypass clear: pointer above range external
// [R10] bypass set: all moves go external
// [R11] index move: 8-bit muxed address
// [R12] pointer move: 16-bit split address
// [R13] write or read strobe low per access
// [R14] stack always in internal ram
// [R15] index move always fits aux ram
module dmsd_decoder #(
    parameter AUX_BYTES = `DMSD_AUX_RAM_BYTES,
    parameter AUX_AW = 8,
    parameter STROBE_LEN = `DMSD_STROBE_LEN
) (
    input wire clock,
    input wire rst_b,
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire req_stack,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire [7:0] req_wdata,
    input wire onchip_xdata_bypass,
    input wire [7:0] muxed_addr_data_port_in,
    input wire [7:0] sreg_rdata,
    output reg sreg_wr_q,
    output reg sreg_rd_q,
    output reg [7:0] sreg_addr_q,
    output reg [7:0] sreg_wdata_q,
    output reg [7:0] muxed_addr_data_port_out_q,
    output reg muxed_addr_data_port_oe_b_q,
    output reg [7:0] high_address_port_out_q,
    output reg high_address_port_oe_b_q,
    output reg addr_latch_q,
    output reg wr_strobe_b_q,
    output reg rd_strobe_b_q,
    output reg busy_q,
    output reg done_q,
    output reg [7:0] rdata_q
);
    // ************************************************************
    // target selection
    // ************************************************************
    localparam T_IRAM = 2'h0;
    localparam T_SREG = 2'h1;
    localparam T_AUX = 2'h2;
    localparam T_EXT = 2'h3;

    function [1:0] pick_target;
        input [1:0] kind;
        input stack;
        input bypass;
        input [15:0] addr;
        begin
            if (stack) begin
                pick_target = T_IRAM; // R14
            end else if (kind == `DMSD_KIND_DIRECT) begin
                if (addr[7:0] > `DMSD_LOWER_RAM_TOP) begin
                    pick_target = T_SREG; // R3
                end else begin
                    pick_target = T_IRAM; // R1
                end
            end else if (kind == `DMSD_KIND_INDIRECT) begin
                pick_target = T_IRAM; // R1 R2 R4
            end else if (bypass) begin
                pick_target = T_EXT; // R10
            end else if (kind == `DMSD_KIND_XMOVE_IDX) begin
                pick_target = T_AUX; // R6 R15
            end else if ({16'h0000, addr} < AUX_BYTES) begin
                pick_target = T_AUX; // R5 R6
            end else begin
                pick_target = T_EXT; // R9
            end
        end
    endfunction

    wire [1:0] target = pick_target(req_kind, req_stack, onchip_xdata_bypass, req_addr);
    wire take = req_valid & ~busy_q;

    // ************************************************************
    // on-chip arrays: 256-byte internal ram and aux ram
    // ************************************************************
    wire [7:0] iram_rdata;
    wire [7:0] aux_rdata;
    wire iram_we = take & req_write & (target == T_IRAM);
    wire aux_we = take & req_write & (target == T_AUX);

    dmsd_ram #(.AW(8), .DEPTH(`DMSD_IRAM_BYTES)) u_iram (
        .clock(clock),
        .wr_en(iram_we),
        .addr(req_addr[7:0]),
        .wdata(req_wdata),
        .rdata(iram_rdata)
    );

    // aux ram access never touches the bus pins
    dmsd_ram #(.AW(AUX_AW), .DEPTH(AUX_BYTES)) u_aux (
        .clock(clock),
        .wr_en(aux_we),
        .addr(req_addr[AUX_AW-1:0]),
        .wdata(req_wdata),
        .rdata(aux_rdata)
    ); // R7

    // ************************************************************
    // port input synchroniser
    // ************************************************************
    reg [7:0] p0_meta_q;
    reg [7:0] p0_sync_q;

    always @(posedge clock) begin
        p0_meta_q <= muxed_addr_data_port_in;
        p0_sync_q <= p0_meta_q;
    end

    // ************************************************************
    // sequencing
    // ************************************************************
    reg [1:0] phase_q;
    reg [1:0] local_tgt_q;
    reg local_pend_q;
    reg ext_write_q;
    reg [7:0] ext_wdata_q;
    reg [7:0] strobe_cnt_q;

    always @(posedge clock) begin
        if (!rst_b) begin
            phase_q <= `DMSD_PH_IDLE;
            local_tgt_q <= T_IRAM;
            local_pend_q <= 1'b0;
            ext_write_q <= 1'b0;
            ext_wdata_q <= 8'h00;
            strobe_cnt_q <= 8'h00;
            sreg_wr_q <= 1'b0;
            sreg_rd_q <= 1'b0;
            sreg_addr_q <= 8'h00;
            sreg_wdata_q <= 8'h00;
            muxed_addr_data_port_out_q <= `DMSD_PORT_RESET;
            muxed_addr_data_port_oe_b_q <= 1'b1;
            high_address_port_out_q <= `DMSD_PORT_RESET;
            high_address_port_oe_b_q <= 1'b0;
            addr_latch_q <= 1'b0;
            wr_strobe_b_q <= 1'b1;
            rd_strobe_b_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            sreg_wr_q <= 1'b0;
            sreg_rd_q <= 1'b0;
            local_pend_q <= 1'b0;
            high_address_port_oe_b_q <= 1'b0; // R8
            if (local_pend_q) begin
                // array read data is valid one cycle after the request
                if (local_tgt_q == T_IRAM) begin
                    rdata_q <= iram_rdata;
                end else if (local_tgt_q == T_AUX) begin
                    rdata_q <= aux_rdata;
                end else begin
                    rdata_q <= sreg_rdata;
                end
                done_q <= 1'b1;
                busy_q <= 1'b0;
            end
            case (phase_q)
                `DMSD_PH_IDLE: begin
                    if (take) begin
                        busy_q <= 1'b1;
                        if (target == T_EXT) begin
                            ext_write_q <= req_write;
                            ext_wdata_q <= req_wdata;
                            muxed_addr_data_port_out_q <= req_addr[7:0]; // R11 R12
                            muxed_addr_data_port_oe_b_q <= 1'b0;
                            if (req_kind == `DMSD_KIND_XMOVE_PTR) begin
                                high_address_port_out_q <= req_addr[15:8]; // R12
                            end
                            addr_latch_q <= 1'b1;
                            phase_q <= `DMSD_PH_ADDR;
                        end else begin
                            local_tgt_q <= target;
                            local_pend_q <= 1'b1;
                            if (target == T_SREG) begin
                                sreg_addr_q <= req_addr[7:0]; // R4
                                sreg_wdata_q <= req_wdata;
                                sreg_wr_q <= req_write;
                                sreg_rd_q <= ~req_write;
                            end
                        end
                    end
                end
                `DMSD_PH_ADDR: begin
                    addr_latch_q <= 1'b0;
                    strobe_cnt_q <= STROBE_LEN[7:0];
                    if (ext_write_q) begin
                        muxed_addr_data_port_out_q <= ext_wdata_q;
                        wr_strobe_b_q <= 1'b0; // R13
                    end else begin
                        muxed_addr_data_port_oe_b_q <= 1'b1;
                        rd_strobe_b_q <= 1'b0; // R13
                    end
                    phase_q <= `DMSD_PH_STROBE;
                end
                `DMSD_PH_STROBE: begin
                    if (strobe_cnt_q > 8'h01) begin
                        strobe_cnt_q <= strobe_cnt_q - 8'h01;
                    end else begin
                        wr_strobe_b_q <= 1'b1;
                        rd_strobe_b_q <= 1'b1;
                        phase_q <= `DMSD_PH_DONE;
                    end
                end
                default: begin
                    // pin data lags two flops, so it is taken here; needs a strobe of 2 or more
                    if (!ext_write_q) begin
                        rdata_q <= p0_sync_q;
                    end
                    muxed_addr_data_port_oe_b_q <= 1'b1;
                    done_q <= 1'b1;
                    busy_q <= 1'b0;
                    phase_q <= `DMSD_PH_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== sim/dmsd_ext_mem.sv ====
// behavioural external data memory on the multiplexed bus
`timescale 1ns/1ps
module dmsd_ext_mem (
    input wire clock,
    input wire ale,
    input wire [7:0] a_hi,
    input wire [7:0] ad_out,
    input wire wr_b,
    input wire rd_b,
    output wire [7:0] ad_in
);
    logic [7:0] mem [0:65535];
    logic [15:0] lat_q = 16'h0000;
    logic [7:0] idle_q = 8'h00;
    // a released bus must not keep the last byte, so it shows a changing pattern
    assign ad_in = rd_b ? idle_q : mem[lat_q];
    always @(posedge clock) begin
        idle_q <= ~idle_q;
        // index moves leave the high byte as paged by the held high port
        if (ale)
            lat_q <= {a_hi, ad_out};
        if (!wr_b)
            mem[lat_q] <= ad_out;
    end
endmodule

// ==== sim/dmsd_decoder_props.sv ====
// port assertions for the data memory space decoder
`timescale 1ns/1ps
module dmsd_decoder_props #(
    parameter AUX_BYTES = 256,
    parameter STROBE_LEN = 2
) (
    input wire clock,
    input wire rst_b,
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire req_stack,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire onchip_xdata_bypass,
    input wire sreg_wr_q,
    input wire sreg_rd_q,
    input wire [7:0] muxed_addr_data_port_out_q,
    input wire muxed_addr_data_port_oe_b_q,
    input wire [7:0] high_address_port_out_q,
    input wire high_address_port_oe_b_q,
    input wire addr_latch_q,
    input wire wr_strobe_b_q,
    input wire rd_strobe_b_q,
    input wire busy_q,
    input wire done_q
);
    // ****************************************
    // request classes
    // ****************************************
    localparam int EXT_LAT = STROBE_LEN + 3;
    wire take = req_valid && !busy_q && rst_b;
    wire on_chip = req_kind[1] && !onchip_xdata_bypass && (!req_kind[0] || req_addr < AUX_BYTES);
    wire ext = req_kind[1] && !req_stack && !on_chip;
    logic wr_held_q = 1'b0;
    always @(posedge clock)
        if (take)
            wr_held_q <= req_write;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence bus_quiet;
        wr_strobe_b_q && rd_strobe_b_q && muxed_addr_data_port_oe_b_q;
    endsequence
    sequence strobe_pulse;
        (wr_strobe_b_q == !wr_held_q && rd_strobe_b_q == wr_held_q) [*2];
    endsequence
    AST_LOCAL_DONE: assert property (take && !ext |-> ##1 busy_q ##1 done_q)
        else $error("local access not done in two cycles");
    AST_DIRECT_SREG: assert property (take && req_kind == 2'h0 && req_addr[7] && !req_stack
        |=> sreg_wr_q == wr_held_q && sreg_rd_q == !wr_held_q)
        else $error("direct upper access missed register space");
    AST_NO_SREG: assert property (take && !req_kind[1]
        && (req_kind[0] || req_stack || !req_addr[7]) |=> !sreg_wr_q && !sreg_rd_q)
        else $error("ram access touched register space");
    AST_AUX_QUIET: assert property (take && on_chip |=> bus_quiet [*2])
        else $error("on-chip move disturbed the bus");
    AST_P2_OUT: assert property (!high_address_port_oe_b_q)
        else $error("high address port not driven");
    AST_EXT_ADDR: assert property (take && ext |=> addr_latch_q
        && !muxed_addr_data_port_oe_b_q && muxed_addr_data_port_out_q == $past(req_addr[7:0]))
        else $error("external address phase wrong");
    AST_HIGH_BYTE: assert property (take && ext |=> high_address_port_out_q ==
        ($past(req_kind[0]) ? $past(req_addr[15:8]) : $past(high_address_port_out_q)))
        else $error("high address byte wrong");
    AST_STROBE: assert property (take && ext |-> ##2 strobe_pulse
        ##1 (wr_strobe_b_q && rd_strobe_b_q) ##1 bus_quiet)
        else $error("strobe wrong");
    AST_EXT_DONE: assert property (take && ext |-> ##EXT_LAT done_q)
        else $error("external access not done in time");
endmodule
bind dmsd_decoder dmsd_decoder_props #(.AUX_BYTES(AUX_BYTES), .STROBE_LEN(STROBE_LEN)) u_props (
    .clock(clock),
    .rst_b(rst_b),
    .req_valid(req_valid),
    .req_kind(req_kind),
    .req_stack(req_stack),
    .req_write(req_write),
    .req_addr(req_addr),
    .onchip_xdata_bypass(onchip_xdata_bypass),
    .sreg_wr_q(sreg_wr_q),
    .sreg_rd_q(sreg_rd_q),
    .muxed_addr_data_port_out_q(muxed_addr_data_port_out_q),
    .muxed_addr_data_port_oe_b_q(muxed_addr_data_port_oe_b_q),
    .high_address_port_out_q(high_address_port_out_q),
    .high_address_port_oe_b_q(high_address_port_oe_b_q),
    .addr_latch_q(addr_latch_q),
    .wr_strobe_b_q(wr_strobe_b_q),
    .rd_strobe_b_q(rd_strobe_b_q),
    .busy_q(busy_q),
    .done_q(done_q)
);

// ==== sim/test_data_memory_space_decoder.sv ====
// self-checking bench for the data memory space decoder
`timescale 1ns/1ps
module test_data_memory_space_decoder;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic [1:0] req_kind = 2'h0;
    logic req_stack = 1'b0;
    logic req_write = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic onchip_xdata_bypass = 1'b0;
    wire [7:0] muxed_addr_data_port_in, muxed_addr_data_port_out_q, high_address_port_out_q;
    wire [7:0] sreg_addr_q, sreg_wdata_q, rdata_q;
    wire sreg_wr_q, sreg_rd_q, muxed_addr_data_port_oe_b_q, high_address_port_oe_b_q;
    wire addr_latch_q, wr_strobe_b_q, rd_strobe_b_q, busy_q, done_q;
    // scrambled so a register read can never pass for a ram read
    wire [7:0] sreg_rdata = sreg_addr_q ^ 8'h5A;
    int bad_count = 0;
    int checked = 0;
    initial forever #12.5 clock = ~clock;
    dmsd_decoder uut (
        .clock(clock),
        .rst_b(rst_b),
        .req_valid(req_valid),
        .req_kind(req_kind),
        .req_stack(req_stack),
        .req_write(req_write),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .onchip_xdata_bypass(onchip_xdata_bypass),
        .muxed_addr_data_port_in(muxed_addr_data_port_in),
        .sreg_rdata(sreg_rdata),
        .sreg_wr_q(sreg_wr_q),
        .sreg_rd_q(sreg_rd_q),
        .sreg_addr_q(sreg_addr_q),
        .sreg_wdata_q(sreg_wdata_q),
        .muxed_addr_data_port_out_q(muxed_addr_data_port_out_q),
        .muxed_addr_data_port_oe_b_q(muxed_addr_data_port_oe_b_q),
        .high_address_port_out_q(high_address_port_out_q),
        .high_address_port_oe_b_q(high_address_port_oe_b_q),
        .addr_latch_q(addr_latch_q),
        .wr_strobe_b_q(wr_strobe_b_q),
        .rd_strobe_b_q(rd_strobe_b_q),
        .busy_q(busy_q),
        .done_q(done_q),
        .rdata_q(rdata_q)
    );
    dmsd_ext_mem ext (.clock(clock), .ale(addr_latch_q), .a_hi(high_address_port_out_q),
        .ad_out(muxed_addr_data_port_out_q), .wr_b(wr_strobe_b_q), .rd_b(rd_strobe_b_q),
        .ad_in(muxed_addr_data_port_in));
    task automatic stop_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic acc(input logic [1:0] k, input logic st, input logic w, input logic [15:0] a,
        input logic [7:0] d);
        int n;
        @(negedge clock);
        {req_valid, req_kind, req_stack, req_write, req_addr, req_wdata} = {1'b1, k, st, w, a, d};
        @(negedge clock);
        req_valid = 1'b0;
        n = 0;
        while (done_q !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        if (done_q !== 1'b1) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] exp);
        acc(k, 1'b0, 1'b0, a, 8'h00);
        cmp8(exp, rdata_q);
    endtask
    task automatic t_internal;
        acc(2'h0, 1'b0, 1'b1, 16'h0010, 8'h11);
        rd(2'h1, 16'h0010, 8'h11);
        acc(2'h1, 1'b0, 1'b1, 16'h00A0, 8'h22);
        rd(2'h0, 16'h00A0, 8'hFA);
        rd(2'h1, 16'h00A0, 8'h22);
        acc(2'h0, 1'b0, 1'b1, 16'h00A0, 8'h99);
        cmp8(8'h99, sreg_wdata_q);
        cmp8(8'hA0, sreg_addr_q);
        rd(2'h1, 16'h00A0, 8'h22);
        acc(2'h0, 1'b1, 1'b1, 16'h00B0, 8'h33);
        rd(2'h1, 16'h00B0, 8'h33);
        $display("test internal finished");
    endtask
    task automatic t_aux;
        acc(2'h2, 1'b0, 1'b1, 16'h00A0, 8'h44);
        rd(2'h3, 16'h00A0, 8'h44);
        acc(2'h3, 1'b0, 1'b1, 16'h00FF, 8'h66);
        rd(2'h2, 16'h00FF, 8'h66);
        acc(2'h3, 1'b0, 1'b1, 16'h0100, 8'h55);
        rd(2'h3, 16'h0100, 8'h55);
        cmp8(8'h01, high_address_port_out_q);
        $display("test aux finished");
    endtask
    task automatic t_ext;
        onchip_xdata_bypass = 1'b1;
        acc(2'h3, 1'b0, 1'b1, 16'h00A0, 8'h77);
        rd(2'h2, 16'h00A0, 8'h77);
        onchip_xdata_bypass = 1'b0;
        rd(2'h3, 16'h00A0, 8'h44);
        $display("test external finished");
    endtask
    initial begin
        repeat (20) @(negedge clock);
        cmp8(8'hE0, {wr_strobe_b_q, rd_strobe_b_q, muxed_addr_data_port_oe_b_q,
            high_address_port_oe_b_q, busy_q, done_q, 2'b00});
        cmp8(8'hFF, high_address_port_out_q);
        rst_b = 1'b1;
        t_internal();
        t_aux();
        t_ext();
        stop_test();
    end
endmodule
